// ===== dv/asr_fe_model.sv
// Purpose: Behavioural analog front end: converter only; mux and sample-hold controls are ignored
// Assumes: One conversion per conv_start pulse
// Notes:   Result is only valid while done is high; otherwise it toggles
`timescale 1ns/10ps
`default_nettype none
module asr_fe_model (
  input  wire logic                       i_clk,  // System clock
  input  wire asr_pkg::asr_fe_t           i_fe,   // Controls from sequencer
  input  wire logic [asr_pkg::DATA_W-1:0] i_data, // Next result to return
  input  wire logic                       i_slow, // Long conversion time
  output logic                            o_done, // Conversion finished
  output logic      [asr_pkg::DATA_W-1:0] o_data  // Result
);
  int cnt = 0;
  initial begin
    o_done = 1'b0;
    o_data = 10'h155;
  end
  // Done held five cycles, long enough for the two-flop sync
  always @(posedge i_clk) begin
    if (i_fe.conv_start === 1'b1) begin
      cnt <= i_slow ? 36 : 7;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    o_done <= (cnt > 1 && cnt <= 6);
    // Stale data would hide a late capture, so it changes every cycle while done is low
    o_data <= (cnt > 1 && cnt <= 6) ? i_data : ~o_data;
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Purpose: Self-checking bench for the repeat-sequence converter control
// Assumes: Front end model answers every conversion start
// Notes:   Read results are queued by the bus task, checked by a monitor
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                  i_clk;
  logic                  i_reset_n;
  logic                  rd;
  logic                  wr;
  logic                  trig;
  logic                  slow;
  logic                  done;
  logic                  wreq;
  logic                  irq;
  logic [7:0]            addr;
  logic [31:0]           wdata;
  logic [31:0]           rdata;
  logic [31:0]           mux;
  logic [31:0]           seed;
  logic [39:0]           ent;
  logic [9:0]            cdata;
  logic [9:0]            mdata;
  logic [9:0]            exp_buf [16];
  logic [39:0]           expq [$];
  logic [7:0]            offs [5];
  asr_pkg::asr_fe_t      fe;
  int                    failures;
  int                    tests_run;
  int                    cyc;

  asr_adc_seq u_dut (
    .i_clk             (i_clk),
    .i_reset_n         (i_reset_n),
    .i_avs_address     (addr),
    .i_avs_read        (rd),
    .i_avs_write       (wr),
    .i_avs_writedata   (wdata),
    .o_avs_readdata    (rdata),
    .o_avs_waitrequest (wreq),
    .i_conv_trig       (trig),
    .i_conv_done       (done),
    .i_conv_data       (mdata),
    .o_fe              (fe),
    .o_irq_req         (irq)
  );

  asr_fe_model u_fe (
    .i_clk  (i_clk),
    .i_fe   (fe),
    .i_data (cdata),
    .i_slow (slow),
    .o_done (done),
    .o_data (mdata)
  );

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Request held until the edge where waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge i_clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    if (!w) expq.push_back({a, e});
    // Only the bench timeout ends a stuck wait
    do begin
      @(posedge i_clk);
    end while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wait_sampling_active();
    int n;
    n = 0;
    while (fe.sh_sample !== asr_pkg::SH_FIRST && n < 200) begin
      @(negedge i_clk);
      n++;
    end
  endtask

  task automatic pulse_trig();
    @(posedge i_clk);
    trig <= 1'b1;
    repeat (6) @(posedge i_clk);
    trig <= 1'b0;
  endtask

  task automatic round();
    for (int k = 0; k < 16; k++) begin
      wait_sampling_active();
      chk("sh_sample", 32'(asr_pkg::SH_FIRST), 32'(fe.sh_sample));
      chk("pos_sel", 32'h0, 32'(fe.pos_sel));
      chk("neg_sel", 32'h0, 32'(fe.neg_sel));
      chk("irq early", 32'h0, 32'(irq));
      seed = xs(seed);
      cdata <= seed[9:0];
      slow <= seed[10];
      exp_buf[k] = seed[9:0];
      pulse_trig();
    end
    wait_sampling_active();
    // Last word leaves the two-entry buffer one cycle after sampling resumes
    @(negedge i_clk);
    chk("irq", 32'h1, 32'(irq));
    bus(1'b0, asr_pkg::OFF_STAT, 32'h0, 32'h7);
    bus(1'b1, 8'h44, ~{22'h0, exp_buf[1]}, 32'h0);
    for (int i = 0; i < 16; i++)
      bus(1'b0, 8'h40 + 8'(4 * i), 32'h0, {22'h0, exp_buf[i]});
    @(negedge i_clk);
    chk("irq held", 32'h1, 32'(irq));
    bus(1'b1, asr_pkg::OFF_STAT, 32'h4, 32'h0);
    @(negedge i_clk);
    chk("irq clear", 32'h0, 32'(irq));
  endtask

  always @(posedge i_clk) begin
    if (rd === 1'b1 && wreq === 1'b0) begin
      if (expq.size() == 0) begin
        chk("read queue", 32'h1, 32'h0);
      end else begin
        ent = expq.pop_front();
        chk($sformatf("read %h", ent[39:32]), ent[31:0], rdata);
      end
    end
  end

  // Whole run needs about one thousand cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    failures = 0;
    tests_run = 0;
    cyc = 0;
    seed = 32'hac44;
    i_reset_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    trig = 1'b0;
    slow = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    cdata = 10'h000;
    offs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20};
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    foreach (offs[i]) bus(1'b0, offs[i], 32'h0, 32'h0);
    seed = xs(seed);
    bus(1'b1, 8'h20, seed, 32'h0);
    bus(1'b0, 8'h20, 32'h0, 32'h0);
    seed = xs(seed);
    mux = (seed & 32'h00ff_0f00) | 32'h0000_1100;
    bus(1'b1, asr_pkg::OFF_MUX, mux, 32'h0);
    bus(1'b0, asr_pkg::OFF_MUX, 32'h0, mux);
    seed = xs(seed);
    bus(1'b1, asr_pkg::OFF_SCAN, seed, 32'h0);
    bus(1'b0, asr_pkg::OFF_SCAN, 32'h0, {16'h0, seed[15:0]});
    bus(1'b1, asr_pkg::OFF_CTRL, 32'h0000_023d, 32'h0);
    bus(1'b0, asr_pkg::OFF_CTRL, 32'h0, 32'h0000_023d);
    round();
    round();
    bus(1'b1, asr_pkg::OFF_CTRL, 32'h0000_023c, 32'h0);
    pulse_trig();
    repeat (60) @(negedge i_clk);
    chk("sh idle", 32'h0, 32'(fe.sh_sample));
    bus(1'b0, asr_pkg::OFF_STAT, 32'h0, 32'h11);
    repeat (4) @(posedge i_clk);
    close_out();
  end
endmodule
`default_nettype wire

// ===== rtl/asr_adc_seq.sv
// Purpose: Converter sequencing with a sixteen-word result buffer
// Assumes: Front end holds result data stable while its done level is high
// Notes:   Only the first sample-and-hold channel is ever enabled
`timescale 1ns/10ps
`default_nettype none
module asr_adc_seq #(
  parameter int DATA_W = asr_pkg::DATA_W,
  parameter int PTR_W  = asr_pkg::PTR_W
) (
  input  wire logic                i_clk,             // 20 MHz clock
  input  wire logic                i_reset_n,         // Async reset, active low
  input  wire logic [asr_pkg::AW-1:0] i_avs_address,  // Byte address
  input  wire logic                i_avs_read,        // Read request
  input  wire logic                i_avs_write,       // Write request
  input  wire logic [31:0]         i_avs_writedata,   // Write data
  output logic      [31:0]         o_avs_readdata,    // Read data
  output logic                     o_avs_waitrequest, // Stall
  input  wire logic                i_conv_trig,       // Conversion trigger pin
  input  wire logic                i_conv_done,       // Front end finished
  input  wire logic [DATA_W-1:0]   i_conv_data,       // Front end result
  output asr_pkg::asr_fe_t         o_fe,              // Front end controls
  output logic                     o_irq_req          // Converter interrupt request
);
  localparam int SW = DATA_W + 2;

  logic [1:0]              rst_pipe;
  logic                    rst_n;
  logic [SW-1:0]           pins_s;
  logic                    trig_s, done_s;
  logic [DATA_W-1:0]       data_s;

  logic [31:0]             ctrl_reg, ctrl_next;
  logic [31:0]             mux_reg, mux_next;
  logic [31:0]             scan_reg, scan_next;
  logic                    irq_reg, irq_next;
  logic                    wait_reg, wait_next;
  logic [31:0]             rdata_reg, rdata_next;

  asr_pkg::asr_state_t     state_reg, state_next;
  asr_pkg::asr_fe_t        fe_reg, fe_next;
  logic                    done_reg, done_next;
  logic                    alt_reg, alt_next;
  logic                    trig_d_reg, cdone_d_reg;
  logic [DATA_W-1:0]       cap_reg, cap_next;

  logic [PTR_W-1:0]        ptr_reg, ptr_next;
  logic                    half_reg, half_next;
  logic [DATA_W-1:0]       mem [asr_pkg::BUF_WORDS];

  logic                    push_ready, pop_valid, pop_ready, pop;
  logic [DATA_W-1:0]       pop_data;
  logic [PTR_W-1:0]        widx;
  logic                    last_word;
  logic                    trig_rise, done_rise;
  logic                    wr_en;
  logic [PTR_W-1:0]        spi;
  logic                    split;

  function automatic logic buf_hit(input logic [asr_pkg::AW-1:0] a);
    buf_hit = (a[asr_pkg::AW-1:asr_pkg::AW-2] == asr_pkg::BUF_PAGE);
  endfunction

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  asr_sync #(.W(SW)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_d     ({i_conv_trig, i_conv_done, i_conv_data}),
    .o_q     (pins_s)
  );
  assign trig_s = pins_s[SW-1];
  assign done_s = pins_s[SW-2];
  assign data_s = pins_s[DATA_W-1:0];

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_d_reg  <= 1'b0;
      cdone_d_reg <= 1'b0;
    end else begin
      trig_d_reg  <= trig_s;
      cdone_d_reg <= done_s;
    end
  end
  assign trig_rise = trig_s && !trig_d_reg;
  assign done_rise = done_s && !cdone_d_reg;

  assign spi   = ctrl_reg[asr_pkg::CTL_SPI +: PTR_W];
  assign split = ctrl_reg[asr_pkg::CTL_SPLIT];

  // Bus slave: one wait state, answer at second edge
  assign wr_en = i_avs_write && !wait_reg;

  always_comb begin
    wait_next  = !((i_avs_read || i_avs_write) && wait_reg);
    rdata_next = rdata_reg;
    if (i_avs_read && wait_reg) begin
      rdata_next = 32'h0;
      if (buf_hit(i_avs_address)) begin
        rdata_next[DATA_W-1:0] = mem[i_avs_address[PTR_W+1:2]];
      end else begin
        unique case ({i_avs_address[asr_pkg::AW-1:2], 2'h0})
          asr_pkg::OFF_CTRL: rdata_next = ctrl_reg;
          asr_pkg::OFF_MUX:  rdata_next = mux_reg;
          asr_pkg::OFF_SCAN: rdata_next = scan_reg;
          asr_pkg::OFF_STAT: begin
            rdata_next[asr_pkg::ST_DONE] = done_reg;
            rdata_next[asr_pkg::ST_SAMPLING_ACTIVE] = (state_reg == asr_pkg::st_sample);
            rdata_next[asr_pkg::ST_IRQ] = irq_reg;
            rdata_next[asr_pkg::ST_HALF] = half_reg;
            rdata_next[asr_pkg::ST_PTR +: PTR_W] = ptr_reg;
          end
          default: rdata_next = 32'h0;
        endcase
      end
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    mux_next  = mux_reg;
    scan_next = scan_reg;
    if (wr_en && !buf_hit(i_avs_address)) begin
      unique case ({i_avs_address[asr_pkg::AW-1:2], 2'h0})
        asr_pkg::OFF_CTRL: ctrl_next = i_avs_writedata & asr_pkg::CTRL_WMASK;
        asr_pkg::OFF_MUX:  mux_next = i_avs_writedata & asr_pkg::MUX_WMASK;
        asr_pkg::OFF_SCAN: scan_next = i_avs_writedata & asr_pkg::SCAN_WMASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg  <= asr_pkg::REG_RST;
      mux_reg   <= asr_pkg::REG_RST;
      scan_reg  <= asr_pkg::REG_RST;
      wait_reg  <= 1'b1;
      rdata_reg <= asr_pkg::REG_RST;
    end else begin
      ctrl_reg  <= ctrl_next;
      mux_reg   <= mux_next;
      scan_reg  <= scan_next;
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end
  assign o_avs_waitrequest = wait_reg;
  assign o_avs_readdata    = rdata_reg;

  // Sample/convert sequencer
  always_comb begin
    state_next         = state_reg;
    fe_next            = fe_reg;
    fe_next.conv_start = 1'b0;
    done_next          = done_reg;
    // Alternate clear forces group A at once, not at the next result
    alt_next           = ctrl_reg[asr_pkg::CTL_ALTERNATE_INPUT_SEL] && alt_reg;
    cap_next           = cap_reg;
    unique case (state_reg)
      asr_pkg::st_idle: begin
        if (ctrl_reg[asr_pkg::CTL_AUTO_SAMPLE_ENABLE]) begin
          state_next = asr_pkg::st_sample;
        end
      end
      asr_pkg::st_sample: begin
        if (trig_rise) begin
          state_next         = asr_pkg::st_conv;
          fe_next.conv_start = 1'b1;
          done_next          = 1'b0;
        end
      end
      asr_pkg::st_conv: begin
        if (done_rise) begin
          state_next = asr_pkg::st_push;
          cap_next   = data_s;
        end
      end
      asr_pkg::st_push: begin
        // Hold here while buffer full so no result is lost
        if (push_ready) begin
          done_next  = 1'b1;
          alt_next   = ctrl_reg[asr_pkg::CTL_ALTERNATE_INPUT_SEL] ? ~alt_reg : 1'b0;
          state_next = ctrl_reg[asr_pkg::CTL_AUTO_SAMPLE_ENABLE] ? asr_pkg::st_sample : asr_pkg::st_idle;
        end
      end
    endcase
    fe_next.sh_sample = (state_next == asr_pkg::st_sample) ? asr_pkg::SH_FIRST
                                                            : asr_pkg::SH_NONE;
    // group B only on alternate samples when enabled
    if (alt_next) begin
      fe_next.pos_sel = mux_reg[asr_pkg::MUX_BPOS +: asr_pkg::SEL_W];
      fe_next.neg_sel = mux_reg[asr_pkg::MUX_BNEG];
    end else begin
      // group A positive select passed through
      fe_next.pos_sel = mux_reg[asr_pkg::MUX_APOS +: asr_pkg::SEL_W];
      fe_next.neg_sel = mux_reg[asr_pkg::MUX_ANEG];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= asr_pkg::st_idle;
      fe_reg    <= '0;
      done_reg  <= 1'b0;
      alt_reg   <= 1'b0;
      cap_reg   <= '0;
    end else begin
      state_reg <= state_next;
      fe_reg    <= fe_next;
      done_reg  <= done_next;
      alt_reg   <= alt_next;
      cap_reg   <= cap_next;
    end
  end
  assign o_fe = fe_reg;

  asr_fifo2 #(.W(DATA_W)) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n),
    .i_in_valid  (state_reg == asr_pkg::st_push),
    .o_in_ready  (push_ready),
    .i_in_data   (cap_reg),
    .o_out_valid (pop_valid),
    .i_out_ready (pop_ready),
    .o_out_data  (pop_data)
  );

  // Buffer writes pause while a bus read of the buffer is pending
  assign pop_ready = !(i_avs_read && buf_hit(i_avs_address));
  assign pop       = pop_valid && pop_ready;
  assign widx      = split ? {half_reg, ptr_reg[PTR_W-2:0]} : ptr_reg;
  assign last_word = (ptr_reg == spi);

  always_comb begin
    ptr_next  = ptr_reg;
    half_next = split ? half_reg : 1'b0;
    irq_next  = irq_reg;
    if (wr_en && !buf_hit(i_avs_address) &&
        ({i_avs_address[asr_pkg::AW-1:2], 2'h0} == asr_pkg::OFF_STAT) &&
        i_avs_writedata[asr_pkg::ST_IRQ]) begin
      irq_next = 1'b0;
    end
    if (pop) begin
      if (last_word) begin
        ptr_next  = '0;
        half_next = split ? ~half_reg : 1'b0;
        irq_next  = 1'b1;
      end else begin
        ptr_next = ptr_reg + PTR_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg  <= '0;
      half_reg <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      ptr_reg  <= ptr_next;
      half_reg <= half_next;
      irq_reg  <= irq_next;
    end
  end
  assign o_irq_req = irq_reg;

  always_ff @(posedge i_clk) begin
    if (pop) begin
      mem[widx] <= pop_data;
    end
  end

  // All checks on the one clock, idle while the reset copy is low
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  irq_on_last_a: assert property (pop && last_word |=> irq_reg && ptr_reg == '0)
    else $error("interrupt not raised on last word");
  irq_only_last_a: assert property ($rose(irq_reg) |-> $past(pop && last_word))
    else $error("interrupt raised early");
  ptr_step_a: assert property (pop && !last_word |=> ptr_reg == $past(ptr_reg) + PTR_W'(1))
    else $error("buffer pointer did not step");
  ptr_wrap_a: assert property (pop && last_word && !split |=> widx == '0)
    else $error("pointer did not restart");
  buf_word_a: assert property (pop && !split |=> mem[$past(ptr_reg)] == $past(pop_data))
    else $error("result not stored");
  other_sh_off_a: assert property (fe_reg.sh_sample[asr_pkg::SH_CH-1:1] == '0)
    else $error("other channel active");
  grp_a_sel_a: assert property (!alt_reg |->
    fe_reg.pos_sel == $past(mux_reg[asr_pkg::MUX_APOS +: asr_pkg::SEL_W]))
    else $error("group A select not applied");
  alt_off_a: assert property (!ctrl_reg[asr_pkg::CTL_ALTERNATE_INPUT_SEL] |=> !alt_reg)
    else $error("group B selected while alternate off");
  neg_ref_a: assert property (!alt_reg |-> fe_reg.neg_sel == $past(mux_reg[asr_pkg::MUX_ANEG]))
    else $error("negative select wrong");
  trig_conv_a: assert property (state_reg == asr_pkg::st_sample && trig_rise |=>
    fe_reg.conv_start ##1 !fe_reg.conv_start)
    else $error("trigger did not start conversion");
  done_set_a: assert property (state_reg == asr_pkg::st_push && push_ready |=>
    done_reg && fe_reg.sh_sample[0] == $past(ctrl_reg[asr_pkg::CTL_AUTO_SAMPLE_ENABLE]))
    else $error("done not set after conversion");
  irq_hold_a: assert property (irq_reg && !wr_en |=> irq_reg)
    else $error("interrupt flag dropped");
endmodule
`default_nettype wire

// ===== rtl/asr_fifo2.sv
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Push and pop may happen in the same cycle
// Notes:   Full when two words held; source must wait on ready
`timescale 1ns/10ps
`default_nettype none
module asr_fifo2 #(
  parameter int W = 10
) (
  input  wire logic         i_clk,       // System clock
  input  wire logic         i_rst_n,     // Synchronised reset
  input  wire logic         i_in_valid,  // Source has a word
  output logic              o_in_ready,  // Room for a word
  input  wire logic [W-1:0] i_in_data,   // Source word
  output logic              o_out_valid, // Word available
  input  wire logic         i_out_ready, // Sink takes the word
  output logic      [W-1:0] o_out_data   // Oldest word
);
  logic [W-1:0] mem [2];
  logic [1:0]   cnt_reg, cnt_next;
  logic         wp_reg, wp_next;
  logic         rp_reg, rp_next;
  logic         push, pop;

  assign o_in_ready  = (cnt_reg != 2'h2);
  assign o_out_valid = (cnt_reg != 2'h0);
  assign o_out_data  = mem[rp_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    wp_next  = push ? ~wp_reg : wp_reg;
    rp_next  = pop ? ~rp_reg : rp_reg;
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 2'h0;
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_reg] <= i_in_data;
    end
  end

  fifo_bound_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cnt_reg != 2'h3) else $error("buffer count out of range");
endmodule
`default_nettype wire

// ===== rtl/asr_pkg.sv
// Purpose: Shared constants and types for the repeat-sequence converter control
// Assumes: 32-bit register bus, byte addresses, one aligned word per register
// Notes:   Buffer words sit at BUF_PAGE, index taken from address bits [5:2]
package asr_pkg;
  localparam int DATA_W    = 10;
  localparam int PTR_W     = 4;
  localparam int BUF_WORDS = 16;
  localparam int AW        = 8;
  localparam int SH_CH     = 4;
  localparam int SEL_W     = 4;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MUX  = 8'h04;
  localparam logic [7:0] OFF_SCAN = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [1:0] BUF_PAGE = 2'h1;

  localparam logic [31:0] CTRL_WMASK = 32'h0000_0fff;
  localparam logic [31:0] MUX_WMASK  = 32'h00ff_1f1f;
  localparam logic [31:0] SCAN_WMASK = 32'h0000_ffff;
  localparam logic [31:0] REG_RST    = 32'h0000_0000;

  // Control word fields
  localparam int CTL_AUTO_SAMPLE_ENABLE  = 0;
  localparam int CTL_SPI   = 2;
  localparam int CTL_CHANNELS_PER_SAMPLE  = 6;
  localparam int CTL_SPLIT = 8;
  localparam int CTL_SIM   = 9;
  localparam int CTL_ALTERNATE_INPUT_SEL  = 10;
  localparam int CTL_SCAN  = 11;
  // Input select word fields
  localparam int MUX_APOS  = 0;
  localparam int MUX_ANEG  = 4;
  localparam int MUX_BPOS  = 8;
  localparam int MUX_BNEG  = 12;
  // Status word fields
  localparam int ST_DONE   = 0;
  localparam int ST_SAMPLING_ACTIVE   = 1;
  localparam int ST_IRQ    = 2;
  localparam int ST_HALF   = 3;
  localparam int ST_PTR    = 4;

  localparam logic [SH_CH-1:0] SH_FIRST = 4'h1;
  localparam logic [SH_CH-1:0] SH_NONE  = 4'h0;

  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_sample = 2'b01,
    st_conv   = 2'b10,
    st_push   = 2'b11
  } asr_state_t;

  typedef struct packed {
    logic [SH_CH-1:0] sh_sample;
    logic [SEL_W-1:0] pos_sel;
    logic             neg_sel;
    logic             conv_start;
  } asr_fe_t;
endpackage

// ===== rtl/asr_sync.sv
// Purpose: Two-stage synchroniser for pin-level inputs
// Assumes: Inputs are levels that stay stable for several clocks
// Notes:   Only the second stage is visible to logic
`timescale 1ns/10ps
`default_nettype none
module asr_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,   // System clock
  input  wire logic         i_rst_n, // Synchronised reset
  input  wire logic [W-1:0] i_d,     // Asynchronous levels
  output logic      [W-1:0] o_q      // Synchronised levels
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= i_d;
      q_reg    <= meta_reg;
    end
  end

  assign o_q = q_reg;
endmodule
`default_nettype wire
